// File: hdl/ppfs_pkg.sv
package ppfs_pkg;
  // Register word offsets (byte addresses = index * 4).
  localparam logic [3:0] OFS_P3_DATA = 4'h0;
  localparam logic [3:0] OFS_P3_DATA_HI = 4'h1;
  localparam logic [3:0] OFS_P3_DIR = 4'h2;
  localparam logic [3:0] OFS_P3_DIR_HI = 4'h3;
  localparam logic [3:0] OFS_P3_FSEL = 4'h4;
  localparam logic [3:0] OFS_P3_FSEL_HI = 4'h5;
  localparam logic [3:0] OFS_P0_FSEL = 4'h6;
  localparam logic [3:0] OFS_DBG_MODE = 4'h7;
  localparam logic [3:0] OFS_P3_RISE = 4'h8;
  localparam logic [3:0] OFS_P3_FALL = 4'h9;
  localparam logic [3:0] OFS_UART_CTL = 4'hA;
  localparam logic [3:0] OFS_STATUS = 4'hB;
  localparam logic [3:0] OFS_P3_PIN = 4'hC;
  // Field positions.
  localparam int BIT_P0_PIN5 = 5;
  localparam int BIT_EXT7 = 1;
  localparam int BIT_EXT8 = 9;
  localparam int BIT_UART0_RXE = 0;
  localparam int BIT_UART2_RXE = 1;
  localparam int BIT_STAT_DEBUG_RESET_INPUT = 0;
  localparam int BIT_STAT_INT7 = 1;
  localparam int BIT_STAT_INT8 = 2;
  localparam int BIT_STAT_ERR = 3;
  // Reset values.
  localparam logic [15:0] RST_P3_DATA = 16'h0000;
  localparam logic [15:0] RST_P3_DIR = 16'hFFFF;
  localparam logic [15:0] RST_P3_FSEL = 16'h0000;
  localparam logic [7:0] RST_P0_FSEL = 8'h00;
  localparam logic RST_DBG_MODE = 1'b1;
  localparam logic [15:0] RST_EDGE = 16'h0000;
  localparam logic [1:0] RST_UART_CTL = 2'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } ppfs_state_t;
endpackage : ppfs_pkg

// File: hdl/ppfs_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ppfs_reg_if;
  logic [3:0] idx;
  logic wr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [15:0] cur;
  logic [15:0] nxt;
  modport master (output idx, output wr, output be, output wdata, input nxt);
  modport merge (input idx, input wr, input be, input wdata, input cur, output nxt);
endinterface : ppfs_reg_if
`default_nettype wire

// File: hdl/ppfs_byte_merge.sv
`timescale 1ns/1ns
`default_nettype none
// Merges one bus write into a 16-bit port register. Byte writes reach either byte
// at the full offset through the byte enables, or the high byte through the high-byte alias offset.
module ppfs_byte_merge
  import ppfs_pkg::*;
#(
  parameter logic [3:0] FULL_IDX = 4'h0,
  parameter logic [3:0] HIGH_IDX = 4'h1
) (
  // Register access.
  input wire logic [3:0] idx_i,
  input wire logic wr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic [15:0] cur_i,
  // Merged value.
  output logic [15:0] nxt_o
);
  wire hit_full = wr_i && (idx_i == FULL_IDX);
  wire hit_high = wr_i && (idx_i == HIGH_IDX);
  wire [7:0] lo_val = (hit_full && be_i[0]) ? wdata_i[7:0] : cur_i[7:0];
  wire [7:0] hi_val = (hit_full && be_i[1]) ? wdata_i[15:8]
                    : (hit_high && be_i[0]) ? wdata_i[7:0] : cur_i[15:8];
  assign nxt_o = {hi_val, lo_val};
endmodule : ppfs_byte_merge
`default_nettype wire

// File: hdl/ppfs_top.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Debug mode bit forces pin 5 to debug reset.
// - Data high byte reachable via 8-bit alias.
// - Direction high byte reachable via 8-bit alias.
// - Function-select high byte reachable via 8-bit alias.
// - After reset pin 5 is debug reset.
// - Bit writes act on whole byte.
module ppfs_top
  import ppfs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port 0 pin 5.
  input wire logic port0_pin5_i,
  output logic debug_reset_input_o,
  output logic ext_interrupt_2_input_o,
  // Port 3 pins.
  input wire logic [15:0] port3_pin_i,
  output logic [15:0] port3_pin_o,
  output logic [15:0] port3_pin_oe_o,
  // Alternate functions on port 3.
  output logic ext_interrupt_7_input_o,
  output logic ext_interrupt_8_input_o,
  output logic uart0_receive_input_o,
  output logic uart2_receive_input_o
);
  ppfs_state_t state_ff;
  ppfs_state_t nxt_state;
  logic [3:0] idx_ff;
  logic [3:0] be_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic [15:0] p3_data_ff;
  logic [15:0] p3_dir_ff;
  logic [15:0] p3_fsel_ff;
  logic [7:0] p0_fsel_ff;
  logic dbg_mode_ff;
  logic [15:0] rise_ff;
  logic [15:0] fall_ff;
  logic [1:0] uart_ctl_ff;
  logic err_ff;
  logic [15:0] p3_s1_ff;
  logic [15:0] p3_s2_ff;
  logic [15:0] p3_s3_ff;
  logic [15:0] p3_in_ff;
  logic p0_s1_ff;
  logic p0_s2_ff;
  logic p0_s3_ff;
  logic p0_in_ff;
  logic debug_reset_input_ff;
  logic int2_ff;
  logic int7_ff;
  logic int8_ff;
  logic rx0_ff;
  logic rx2_ff;
  logic [15:0] p3_pin_ff;
  logic [15:0] p3_oe_ff;
  logic [15:0] prev_in_ff;

  // Bus decode.
  wire [3:0] bus_idx = avs_address_i[5:2];
  wire do_wr = (state_ff == ST_WRITE);
  wire lo_be = be_ff[0];

  // Port register merges share one write path through the carrier.
  ppfs_reg_if data_if();
  ppfs_reg_if dir_if();
  ppfs_reg_if fsel_if();
  assign data_if.idx = idx_ff;
  assign data_if.wr = do_wr;
  assign data_if.be = be_ff;
  assign data_if.wdata = wdata_ff;
  assign data_if.cur = p3_data_ff;
  assign dir_if.idx = idx_ff;
  assign dir_if.wr = do_wr;
  assign dir_if.be = be_ff;
  assign dir_if.wdata = wdata_ff;
  assign dir_if.cur = p3_dir_ff;
  assign fsel_if.idx = idx_ff;
  assign fsel_if.wr = do_wr;
  assign fsel_if.be = be_ff;
  assign fsel_if.wdata = wdata_ff;
  assign fsel_if.cur = p3_fsel_ff;

  ppfs_byte_merge #(.FULL_IDX(OFS_P3_DATA), .HIGH_IDX(OFS_P3_DATA_HI)) u_data (
    .idx_i(data_if.idx),
    .wr_i(data_if.wr),
    .be_i(data_if.be),
    .wdata_i(data_if.wdata),
    .cur_i(data_if.cur),
    .nxt_o(data_if.nxt)
  );
  ppfs_byte_merge #(.FULL_IDX(OFS_P3_DIR), .HIGH_IDX(OFS_P3_DIR_HI)) u_dir (
    .idx_i(dir_if.idx),
    .wr_i(dir_if.wr),
    .be_i(dir_if.be),
    .wdata_i(dir_if.wdata),
    .cur_i(dir_if.cur),
    .nxt_o(dir_if.nxt)
  );
  ppfs_byte_merge #(.FULL_IDX(OFS_P3_FSEL), .HIGH_IDX(OFS_P3_FSEL_HI)) u_fsel (
    .idx_i(fsel_if.idx),
    .wr_i(fsel_if.wr),
    .be_i(fsel_if.be),
    .wdata_i(fsel_if.wdata),
    .cur_i(fsel_if.cur),
    .nxt_o(fsel_if.nxt)
  );

  // Writes to the data latch store whole bytes, so input-mode latches in the
  // same byte take whatever the master wrote back after its read.
  wire [15:0] nxt_p3_data = data_if.nxt;

  // Pin function selection.
  wire pin5_is_debug_reset_input = dbg_mode_ff;
  wire pin5_alt = p0_fsel_ff[BIT_P0_PIN5];
  wire sel7 = p3_fsel_ff[BIT_EXT7];
  wire sel8 = p3_fsel_ff[BIT_EXT8];
  wire [15:0] rise_evt = p3_in_ff & ~prev_in_ff & rise_ff;
  wire [15:0] fall_evt = ~p3_in_ff & prev_in_ff & fall_ff;
  wire [15:0] edge_evt = rise_evt | fall_evt;
  wire share_clash = (sel7 && uart_ctl_ff[BIT_UART0_RXE]
                      && (rise_ff[BIT_EXT7] || fall_ff[BIT_EXT7])) ||
                     (sel8 && uart_ctl_ff[BIT_UART2_RXE]
                      && (rise_ff[BIT_EXT8] || fall_ff[BIT_EXT8]));

  // Read mux.
  wire [31:0] rd_mux =
    (idx_ff == OFS_P3_DATA) ? {16'h0000, p3_data_ff} :
    (idx_ff == OFS_P3_DATA_HI) ? {24'h000000, p3_data_ff[15:8]} :
    (idx_ff == OFS_P3_DIR) ? {16'h0000, p3_dir_ff} :
    (idx_ff == OFS_P3_DIR_HI) ? {24'h000000, p3_dir_ff[15:8]} :
    (idx_ff == OFS_P3_FSEL) ? {16'h0000, p3_fsel_ff} :
    (idx_ff == OFS_P3_FSEL_HI) ? {24'h000000, p3_fsel_ff[15:8]} :
    (idx_ff == OFS_P0_FSEL) ? {24'h000000, p0_fsel_ff} :
    (idx_ff == OFS_DBG_MODE) ? {31'h0, dbg_mode_ff} :
    (idx_ff == OFS_P3_RISE) ? {16'h0000, rise_ff} :
    (idx_ff == OFS_P3_FALL) ? {16'h0000, fall_ff} :
    (idx_ff == OFS_UART_CTL) ? {30'h0, uart_ctl_ff} :
    (idx_ff == OFS_STATUS) ? {28'h0000000, err_ff, int8_ff, int7_ff, debug_reset_input_ff} :
    (idx_ff == OFS_P3_PIN) ? {16'h0000, p3_in_ff} : UNMAPPED_DATA;

  // Bus sequencer: capture, then one cycle to act, then release.
  always_comb begin
    nxt_state = ST_IDLE;
    case (state_ff)
      // The edge that shows waitrequest low ends a transfer, so it must not start another.
      ST_IDLE: begin
        if (avs_write_i && avs_waitrequest_o) begin
          nxt_state = ST_WRITE;
        end else if (avs_read_i && avs_waitrequest_o) begin
          nxt_state = ST_READ;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      be_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      avs_waitrequest_o <= !(nxt_state == ST_IDLE && state_ff != ST_IDLE);
      if (state_ff == ST_IDLE) begin
        idx_ff <= bus_idx;
        be_ff <= avs_byteenable_i;
        wdata_ff <= avs_writedata_i;
      end
      if (state_ff == ST_READ) begin
        rdata_ff <= rd_mux;
      end
    end
  end
  assign avs_readdata_o = rdata_ff;

  // Register file.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      p3_data_ff <= RST_P3_DATA;
      p3_dir_ff <= RST_P3_DIR;
      p3_fsel_ff <= RST_P3_FSEL;
      p0_fsel_ff <= RST_P0_FSEL;
      dbg_mode_ff <= RST_DBG_MODE;
      rise_ff <= RST_EDGE;
      fall_ff <= RST_EDGE;
      uart_ctl_ff <= RST_UART_CTL;
    end else begin
      p3_data_ff <= nxt_p3_data;
      p3_dir_ff <= dir_if.nxt;
      p3_fsel_ff <= fsel_if.nxt;
      if (do_wr && lo_be) begin
        if (idx_ff == OFS_P0_FSEL) begin
          p0_fsel_ff <= wdata_ff[7:0];
        end else if (idx_ff == OFS_DBG_MODE) begin
          dbg_mode_ff <= wdata_ff[0];
        end else if (idx_ff == OFS_UART_CTL) begin
          uart_ctl_ff <= wdata_ff[1:0];
        end
      end
      if (do_wr && idx_ff == OFS_P3_RISE) begin
        rise_ff[7:0] <= be_ff[0] ? wdata_ff[7:0] : rise_ff[7:0];
        rise_ff[15:8] <= be_ff[1] ? wdata_ff[15:8] : rise_ff[15:8];
      end
      if (do_wr && idx_ff == OFS_P3_FALL) begin
        fall_ff[7:0] <= be_ff[0] ? wdata_ff[7:0] : fall_ff[7:0];
        fall_ff[15:8] <= be_ff[1] ? wdata_ff[15:8] : fall_ff[15:8];
      end
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      p3_s1_ff <= 16'h0000;
      p3_s2_ff <= 16'h0000;
      p3_s3_ff <= 16'h0000;
      p3_in_ff <= 16'h0000;
      prev_in_ff <= 16'h0000;
      p0_s1_ff <= 1'b0;
      p0_s2_ff <= 1'b0;
      p0_s3_ff <= 1'b0;
      p0_in_ff <= 1'b0;
    end else begin
      p3_s1_ff <= port3_pin_i;
      p3_s2_ff <= p3_s1_ff;
      p3_s3_ff <= p3_s2_ff;
      p3_in_ff <= (p3_s2_ff & p3_s3_ff) | (p3_in_ff & (p3_s2_ff | p3_s3_ff));
      prev_in_ff <= p3_in_ff;
      p0_s1_ff <= port0_pin5_i;
      p0_s2_ff <= p0_s1_ff;
      p0_s3_ff <= p0_s2_ff;
      p0_in_ff <= (p0_s2_ff & p0_s3_ff) | (p0_in_ff & (p0_s2_ff | p0_s3_ff));
    end
  end

  // Alternate function outputs. Interrupt 7 and 8 outputs pulse one cycle per edge; interrupt 2 follows the pin level.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      debug_reset_input_ff <= 1'b0;
      int2_ff <= 1'b0;
      int7_ff <= 1'b0;
      int8_ff <= 1'b0;
      rx0_ff <= 1'b1;
      rx2_ff <= 1'b1;
      p3_pin_ff <= 16'h0000;
      p3_oe_ff <= 16'h0000;
      err_ff <= 1'b0;
    end else begin
      debug_reset_input_ff <= pin5_is_debug_reset_input && p0_in_ff;
      int2_ff <= !pin5_is_debug_reset_input && pin5_alt && p0_in_ff;
      int7_ff <= sel7 && edge_evt[BIT_EXT7];
      int8_ff <= sel8 && edge_evt[BIT_EXT8];
      rx0_ff <= (sel7 && uart_ctl_ff[BIT_UART0_RXE]) ? p3_in_ff[BIT_EXT7] : 1'b1;
      rx2_ff <= (sel8 && uart_ctl_ff[BIT_UART2_RXE]) ? p3_in_ff[BIT_EXT8] : 1'b1;
      p3_pin_ff <= p3_data_ff;
      p3_oe_ff <= ~p3_dir_ff & ~p3_fsel_ff;
      err_ff <= share_clash;
    end
  end
  assign debug_reset_input_o = debug_reset_input_ff;
  assign ext_interrupt_2_input_o = int2_ff;
  assign ext_interrupt_7_input_o = int7_ff;
  assign ext_interrupt_8_input_o = int8_ff;
  assign uart0_receive_input_o = rx0_ff;
  assign uart2_receive_input_o = rx2_ff;
  assign port3_pin_o = p3_pin_ff;
  assign port3_pin_oe_o = p3_oe_ff;

  // Assertions.
  property p_debug_reset_input_override;
    @(posedge mclk_i) disable iff (!rst_n_i)
      dbg_mode_ff |=> !ext_interrupt_2_input_o;
  endproperty
  a_debug_reset_input_override: assert property (p_debug_reset_input_override) else $error("pin5 left debug role");
  property p_data_hi;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (do_wr && idx_ff == OFS_P3_DATA_HI && be_ff[0]) |=> p3_data_ff[15:8] == $past(wdata_ff[7:0]);
  endproperty
  a_data_hi: assert property (p_data_hi) else $error("data high alias write lost");
  property p_dir_hi;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (do_wr && idx_ff == OFS_P3_DIR_HI && be_ff[0]) |=> p3_dir_ff[15:8] == $past(wdata_ff[7:0]);
  endproperty
  a_dir_hi: assert property (p_dir_hi) else $error("direction high alias write lost");
  property p_fsel_hi;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (do_wr && idx_ff == OFS_P3_FSEL_HI && be_ff[0]) |=> p3_fsel_ff[15:8] == $past(wdata_ff[7:0]);
  endproperty
  a_fsel_hi: assert property (p_fsel_hi) else $error("function high alias write lost");
  property p_hi_keeps_lo;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (do_wr && idx_ff == OFS_P3_DATA_HI) |=> $stable(p3_data_ff[7:0]);
  endproperty
  a_hi_keeps_lo: assert property (p_hi_keeps_lo) else $error("alias write hit low byte");
  property p_no_edge7;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!rise_ff[BIT_EXT7] && !fall_ff[BIT_EXT7]) |=> !ext_interrupt_7_input_o;
  endproperty
  a_no_edge7: assert property (p_no_edge7) else $error("int7 fired with no edge select");
  property p_no_edge8;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!rise_ff[BIT_EXT8] && !fall_ff[BIT_EXT8]) |=> !ext_interrupt_8_input_o;
  endproperty
  a_no_edge8: assert property (p_no_edge8) else $error("int8 fired with no edge select");
  property p_reset_debug_reset_input;
    @(posedge mclk_i) !rst_n_i |=> dbg_mode_ff;
  endproperty
  a_reset_debug_reset_input: assert property (p_reset_debug_reset_input) else $error("debug mode not set by reset");
  property p_ack;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (avs_write_i && avs_waitrequest_o && state_ff == ST_IDLE) |-> ##2 !avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("write not answered in two cycles");
endmodule : ppfs_top
`default_nettype wire

// File: sim/ppfs_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Board side of the pins. A pin nobody drives settles at its pull level, so a
// released line never keeps showing the last value that was put on it.
module ppfs_pin_model (
  // Board drive.
  input wire logic [15:0] board_val_i,
  input wire logic [15:0] board_en_i,
  input wire logic pin5_val_i,
  input wire logic pin5_en_i,
  // Device side.
  input wire logic [15:0] dev_out_i,
  input wire logic [15:0] dev_oe_i,
  output logic [15:0] port3_pin_o,
  output logic port0_pin5_o
);
  genvar g;
  for (g = 0; g < 16; g++) begin : g_pin
    assign port3_pin_o[g] = dev_oe_i[g] ? dev_out_i[g] : (board_en_i[g] ? board_val_i[g] : 1'b1);
  end
  // The debug reset pin has an internal pull-down, so undriven it reads low.
  assign port0_pin5_o = pin5_en_i ? pin5_val_i : 1'b0;
endmodule : ppfs_pin_model
`default_nettype wire

// File: sim/port_pin_function_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_select_bench;
  import ppfs_pkg::*;
  typedef struct packed {logic w; logic [3:0] idx; logic [3:0] be; logic [31:0] wd; logic [31:0] ex;} ppfs_row_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic port0_pin5_i;
  logic debug_reset_input_o;
  logic ext_interrupt_2_input_o;
  logic [15:0] port3_pin_i;
  logic [15:0] port3_pin_o;
  logic [15:0] port3_pin_oe_o;
  logic ext_interrupt_7_input_o;
  logic ext_interrupt_8_input_o;
  logic uart0_receive_input_o;
  logic uart2_receive_input_o;
  logic [15:0] board_val = 16'hFFFF;
  logic pin5_val = 1'b0;
  int err_count = 0;
  int compares = 0;
  int int_cnt[2] = '{0, 0};
  logic [31:0] rd;
  ppfs_row_t rows[22];

  always #10 mclk_i = ~mclk_i;

  ppfs_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .port0_pin5_i(port0_pin5_i),
    .debug_reset_input_o(debug_reset_input_o), .ext_interrupt_2_input_o(ext_interrupt_2_input_o),
    .port3_pin_i(port3_pin_i), .port3_pin_o(port3_pin_o), .port3_pin_oe_o(port3_pin_oe_o),
    .ext_interrupt_7_input_o(ext_interrupt_7_input_o),
    .ext_interrupt_8_input_o(ext_interrupt_8_input_o),
    .uart0_receive_input_o(uart0_receive_input_o), .uart2_receive_input_o(uart2_receive_input_o));

  ppfs_pin_model pins (.board_val_i(board_val), .board_en_i(16'hFFFF), .pin5_val_i(pin5_val),
    .pin5_en_i(1'b1), .dev_out_i(port3_pin_o), .dev_oe_i(port3_pin_oe_o),
    .port3_pin_o(port3_pin_i), .port0_pin5_o(port0_pin5_i));

  // Pulses last one cycle, so they are counted away from the launching edge.
  always @(negedge mclk_i) begin
    if (ext_interrupt_7_input_o === 1'b1) int_cnt[0]++;
    if (ext_interrupt_8_input_o === 1'b1) int_cnt[1]++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Waitrequest and read data are taken at the rising edge where waitrequest is low,
  // and the request is released at that same edge.
  task automatic bus(input logic w, input logic [3:0] idx, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_byteenable_i <= be;
    avs_writedata_i <= wd;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", {31'h0, avs_waitrequest_o}, 32'h0000_0000);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, 4'h3, wd, d);
  endtask : wr

  task automatic settle();
    repeat (12) @(posedge mclk_i);
  endtask : settle

  task automatic pin(input int b, input logic v);
    @(posedge mclk_i);
    board_val[b] <= v;
    settle();
  endtask : pin

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #200000;
    err_count++;
    summarize();
  end

  initial begin
    int b;
    logic [31:0] rx;
    rows = '{
      '{0, 4'h0, 4'h3, 0, 32'h0000_0000}, '{0, 4'h2, 4'h3, 0, 32'h0000_FFFF},
      '{0, 4'h3, 4'h1, 0, 32'h0000_00FF}, '{0, 4'h4, 4'h3, 0, 32'h0000_0000},
      '{0, 4'h7, 4'h1, 0, 32'h0000_0001}, '{0, 4'hA, 4'h1, 0, 32'h0000_0000},
      '{1, 4'hD, 4'hF, 32'h1234_5678, 0}, '{0, 4'hD, 4'hF, 0, 32'h0000_0000},
      '{1, 4'h0, 4'h3, 32'h0000_1234, 0}, '{0, 4'h1, 4'h1, 0, 32'h0000_0012},
      '{1, 4'h1, 4'h1, 32'h0000_00AB, 0}, '{0, 4'h0, 4'h3, 0, 32'h0000_AB34},
      '{1, 4'h0, 4'h1, 32'h0000_0077, 0}, '{0, 4'h0, 4'h3, 0, 32'h0000_AB77},
      '{1, 4'h3, 4'h1, 32'h0000_0000, 0}, '{0, 4'h2, 4'h3, 0, 32'h0000_00FF},
      '{1, 4'h2, 4'h2, 32'h0000_5A00, 0}, '{0, 4'h3, 4'h1, 0, 32'h0000_005A},
      '{1, 4'h5, 4'h1, 32'h0000_00C3, 0}, '{0, 4'h4, 4'h3, 0, 32'h0000_C300},
      '{1, 4'h4, 4'h3, 32'h0000_0000, 0}, '{0, 4'h5, 4'h1, 0, 32'h0000_0000}};
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    check("oe after reset", {16'h0, port3_pin_oe_o}, 32'h0000_0000);
    check("uart0 rx idle", {31'h0, uart0_receive_input_o}, 32'h0000_0001);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].idx, rows[i].be, rows[i].wd, rd);
      if (!rows[i].w) check($sformatf("row %0d", i), rd, rows[i].ex);
    end
    settle();
    check("port3 oe", {16'h0, port3_pin_oe_o}, 32'h0000_A500);
    check("port3 out", {16'h0, port3_pin_o}, 32'h0000_AB77);
    wr(OFS_P3_DIR, 32'h0000_FFFF);
    @(posedge mclk_i);
    pin5_val <= 1'b1;
    wr(OFS_P0_FSEL, 32'h0000_0020);
    settle();
    check("debug reset out", {31'h0, debug_reset_input_o}, 32'h0000_0001);
    check("int2 masked", {31'h0, ext_interrupt_2_input_o}, 32'h0000_0000);
    wr(OFS_DBG_MODE, 32'h0000_0000);
    settle();
    check("debug reset off", {31'h0, debug_reset_input_o}, 32'h0000_0000);
    check("int2 on", {31'h0, ext_interrupt_2_input_o}, 32'h0000_0001);
    for (int c = 0; c < 2; c++) begin
      b = (c == 0) ? BIT_EXT7 : BIT_EXT8;
      wr(OFS_P3_FSEL, 32'h1 << b);
      // Edge detection stays off while the receiver owns the pin.
      wr(OFS_UART_CTL, 32'h1 << c);
      pin(b, 1'b0);
      rx = (c == 0) ? {31'h0, uart0_receive_input_o} : {31'h0, uart2_receive_input_o};
      check("rx low", rx, 32'h0000_0000);
      pin(b, 1'b1);
      rx = (c == 0) ? {31'h0, uart0_receive_input_o} : {31'h0, uart2_receive_input_o};
      check("rx high", rx, 32'h0000_0001);
      check("no edge no int", int_cnt[c], 32'h0000_0000);
      wr(OFS_UART_CTL, 32'h0000_0000);
      pin(b, 1'b0);
      rx = (c == 0) ? {31'h0, uart0_receive_input_o} : {31'h0, uart2_receive_input_o};
      check("rx stopped", rx, 32'h0000_0001);
      wr(OFS_P3_RISE, 32'h1 << b);
      pin(b, 1'b1);
      check("rise int", int_cnt[c], 32'h0000_0001);
      wr(OFS_P3_FALL, 32'h1 << b);
      pin(b, 1'b0);
      pin(b, 1'b1);
      check("both edges int", int_cnt[c], 32'h0000_0003);
      wr(OFS_P3_RISE, 32'h0000_0000);
      wr(OFS_P3_FALL, 32'h0000_0000);
      pin(b, 1'b0);
      check("edges off", int_cnt[c], 32'h0000_0003);
    end
    // Break the sharing rule on purpose: receiver on while an edge is selected.
    wr(OFS_UART_CTL, 32'h0000_0002);
    wr(OFS_P3_RISE, 32'h1 << BIT_EXT8);
    bus(1'b0, OFS_STATUS, 4'hF, 32'h0000_0000, rd);
    check("conflict flag", rd, 32'h1 << BIT_STAT_ERR);
    wr(OFS_UART_CTL, 32'h0000_0000);
    bus(1'b0, OFS_STATUS, 4'hF, 32'h0000_0000, rd);
    check("conflict clear", rd, 32'h0000_0000);
    bus(1'b0, OFS_P3_PIN, 4'hF, 32'h0000_0000, rd);
    check("pin readback", rd, 32'h0000_FFFF & ~((32'h1 << BIT_EXT7) | (32'h1 << BIT_EXT8)));
    // A reset in mid-run must hand pin 5 back to its debug role.
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check("oe in reset", {16'h0, port3_pin_oe_o}, 32'h0000_0000);
    check("int2 in reset", {31'h0, ext_interrupt_2_input_o}, 32'h0000_0000);
    rst_n_i <= 1'b1;
    bus(1'b0, OFS_DBG_MODE, 4'h1, 32'h0000_0000, rd);
    check("debug mode after reset", rd, {31'h0, RST_DBG_MODE});
    bus(1'b0, OFS_P3_RISE, 4'h3, 32'h0000_0000, rd);
    check("rise after reset", rd, {16'h0, RST_EDGE});
    settle();
    check("debug reset again", {31'h0, debug_reset_input_o}, 32'h0000_0001);
    summarize();
  end
endmodule : port_pin_function_select_bench
`default_nettype wire
